// ===== hdl/rrc_top.sv
// Remote reconfiguration control with serial path and register slave
//
// What this block does
// - Everything samples and updates on rising clock.
// - Shift mode moves data out, takes bit in.
// - Capture loads status; update writes config registers while factory image runs.
// - Watchdog reset input holds timer at start.
// - Rising reconfig request in user mode starts a new load.
// - Serial output is shift register bit, registered.
// - Three-bit page select drives memory page.
// - Memory holds eight pages, one image each.
// - Remote scheme powers up loading page zero.
// - Successful application load enters user mode.
// - Load error or timeout reloads factory image.
// - Local scheme powers up loading page one.
// - Local scheme load error falls back to factory.
// - Five-bit cause status, zero at power-on.
// - Twelve-bit timeout, zero, factory-only writable.
`timescale 1ns/1ps
`default_nettype none
module rrc_top
    import rrc_pkg::*;
#(
    parameter int WD_PRESCALE = RRC_WD_TICK_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    // Serial configuration path
    input wire logic shift_not_load,
    input wire logic capture_not_update,
    input wire logic serial_in,
    output logic serial_out,
    input wire logic watchdog_reset,
    input wire logic reconfig_request,
    // Configuration memory side
    input wire logic remote_local_scheme_select,
    input wire logic ext_config_request,
    input wire logic load_done,
    input wire logic load_crc_error,
    input wire logic load_ext_error,
    output logic [RRC_PAGE_W-1:0] page_select,
    output logic config_loading,
    output logic user_mode,
    output logic app_running,
    // AXI4-Lite slave
    input wire logic [RRC_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [RRC_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [RRC_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [RRC_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef struct packed {
        rrc_state_e fsm;
        logic [RRC_SR_W-1:0] sr;
        logic [RRC_STAT_W-1:0] cause;
        logic app;
        logic [RRC_PAGE_W-1:0] page_out;
        logic [RRC_PAGE_W-1:0] page_next;
        logic wd_en;
        logic [RRC_WD_TO_W-1:0] wd_to;
        logic req_prev;
        logic ext_prev;
        logic kick;
        logic aw_got;
        logic [RRC_AW-1:0] aw_addr;
        logic w_got;
        logic [RRC_DW-1:0] w_data;
        logic [3:0] w_strb;
        logic aw_rdy;
        logic w_rdy;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [RRC_DW-1:0] rdata;
        logic [1:0] rresp;
    } rrc_top_s;

    rrc_top_s s_reg;
    rrc_top_s s_next;

    rrc_wd_if wd_link ();

    // One-hot cause word for the status field
    function automatic logic [RRC_STAT_W-1:0] cause_vec(input int idx);
        logic [RRC_STAT_W-1:0] v;
        v = '0;
        v[idx] = 1'b1;
        return v;
    endfunction

    // Known offsets answer OKAY, anything else SLVERR
    function automatic logic [1:0] addr_resp(input logic [RRC_AW-1:0] a);
        logic [RRC_AW-1:0] w;
        w = {a[RRC_AW-1:2], 2'b00};
        if (w == RRC_OFS_CTRL || w == RRC_OFS_STATUS ||
            w == RRC_OFS_WDCFG || w == RRC_OFS_PAGE) begin
            return RRC_RESP_OKAY;
        end
        return RRC_RESP_SLVERR;
    endfunction

    // Read data; reserved bits and unmapped words read zero
    function automatic logic [RRC_DW-1:0] rd_word(input rrc_top_s s,
            input logic [RRC_AW-1:0] a);
        logic [RRC_DW-1:0] d;
        logic [RRC_AW-1:0] w;
        d = '0;
        w = {a[RRC_AW-1:2], 2'b00};
        if (w == RRC_OFS_STATUS) begin
            d[RRC_STAT_CAUSE_LSB +: RRC_STAT_W] = s.cause;
            d[RRC_STAT_APP_BIT] = s.app;
            d[RRC_STAT_PAGE_LSB +: RRC_PAGE_W] = s.page_out;
            d[RRC_STAT_LOAD_BIT] = (s.fsm != RRC_ST_USER);
            d[RRC_STAT_USER_BIT] = (s.fsm == RRC_ST_USER);
        end else if (w == RRC_OFS_WDCFG) begin
            d[RRC_WD_TO_LSB +: RRC_WD_TO_W] = s.wd_to;
            d[RRC_WD_EN_BIT] = s.wd_en;
        end else if (w == RRC_OFS_PAGE) begin
            d[RRC_PAGE_W-1:0] = s.page_next;
        end
        return d;
    endfunction

    logic sw_reconf;
    logic sw_kick;
    logic core_req;
    logic ext_req;
    logic [RRC_AW-1:0] wr_word;

    always_comb begin
        s_next = s_reg;
        sw_reconf = 1'b0;
        sw_kick = 1'b0;
        wr_word = '0;

        // Bus write: address and data taken in either order
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        if (s_axi_awvalid && s_reg.aw_rdy) begin
            s_next.aw_got = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_reg.w_rdy) begin
            s_next.w_got = 1'b1;
            s_next.w_data = s_axi_wdata;
            s_next.w_strb = s_axi_wstrb;
        end
        if (s_next.aw_got && s_next.w_got && !s_next.bvalid) begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = addr_resp(s_next.aw_addr);
            wr_word = {s_next.aw_addr[RRC_AW-1:2], 2'b00};
            if (wr_word == RRC_OFS_CTRL && s_next.w_strb[0]) begin
                sw_reconf = s_next.w_data[RRC_CTRL_RECONF_BIT];
                sw_kick = s_next.w_data[RRC_CTRL_KICK_BIT];
            end
        end
        s_next.aw_rdy = !s_next.aw_got;
        s_next.w_rdy = !s_next.w_got;

        // Bus read: one outstanding, answered the cycle after the address
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_reg.ar_rdy) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = rd_word(s_reg, s_axi_araddr);
            s_next.rresp = addr_resp(s_axi_araddr);
        end
        s_next.ar_rdy = !s_next.rvalid;

        // Serial path: shift, capture or update
        if (shift_not_load) begin
            s_next.sr = {serial_in, s_reg.sr[RRC_SR_W-1:1]};
        end else if (capture_not_update) begin
            s_next.sr = {s_reg.cause, s_reg.app, s_reg.page_next,
                         s_reg.wd_en, s_reg.wd_to};
        end else if (!s_reg.app) begin
            // Update only takes effect while the factory image runs
            s_next.page_next = s_reg.sr[RRC_SR_PAGE_LSB +: RRC_PAGE_W];
            s_next.wd_en = s_reg.sr[RRC_SR_EN_BIT];
            s_next.wd_to = s_reg.sr[RRC_SR_TO_LSB +: RRC_WD_TO_W];
        end

        // Register writes to configuration, factory image only
        if (s_next.bvalid && !s_reg.bvalid && !s_reg.app) begin
            if (wr_word == RRC_OFS_WDCFG) begin
                if (s_next.w_strb[1:0] == 2'b11) begin
                    s_next.wd_to =
                        s_next.w_data[RRC_WD_TO_LSB +: RRC_WD_TO_W];
                end
                if (s_next.w_strb[2]) begin
                    s_next.wd_en = s_next.w_data[RRC_WD_EN_BIT];
                end
            end else if (wr_word == RRC_OFS_PAGE && s_next.w_strb[0]) begin
                s_next.page_next = s_next.w_data[RRC_PAGE_W-1:0];
            end
        end

        // Request edges seen on sampled inputs
        s_next.req_prev = reconfig_request;
        s_next.ext_prev = ext_config_request;
        core_req = (reconfig_request && !s_reg.req_prev) || sw_reconf;
        ext_req = ext_config_request && !s_reg.ext_prev;
        s_next.kick = watchdog_reset || sw_kick;

        // Configuration sequencer
        case (s_reg.fsm)
            RRC_ST_BOOT: begin
                // Strap is caught after reset release, never under it
                if (remote_local_scheme_select) begin
                    s_next.page_out = RRC_PAGE_FACTORY;
                    s_next.page_next = RRC_PAGE_FACTORY;
                    s_next.app = 1'b0;
                end else begin
                    s_next.page_out = RRC_PAGE_LOCAL_APP;
                    s_next.page_next = RRC_PAGE_LOCAL_APP;
                    s_next.app = 1'b1;
                end
                s_next.fsm = RRC_ST_LOAD;
            end
            RRC_ST_LOAD: begin
                if (load_done) begin
                    s_next.fsm = RRC_ST_USER;
                end else if (load_crc_error || load_ext_error) begin
                    // Any failed load retries from the factory page
                    s_next.cause = load_crc_error ?
                        cause_vec(RRC_CAUSE_CRC) :
                        cause_vec(RRC_CAUSE_EXT_ERR);
                    s_next.page_out = RRC_PAGE_FACTORY;
                    s_next.app = 1'b0;
                end
            end
            RRC_ST_USER: begin
                if (wd_link.expire) begin
                    s_next.cause = cause_vec(RRC_CAUSE_WDOG);
                    s_next.page_out = RRC_PAGE_FACTORY;
                    s_next.app = 1'b0;
                    s_next.fsm = RRC_ST_LOAD;
                end else if (ext_req) begin
                    s_next.cause = cause_vec(RRC_CAUSE_EXT_REQ);
                    s_next.page_out = RRC_PAGE_FACTORY;
                    s_next.app = 1'b0;
                    s_next.fsm = RRC_ST_LOAD;
                end else if (core_req) begin
                    s_next.cause = cause_vec(RRC_CAUSE_CORE);
                    // Factory jumps to chosen page, application back
                    if (s_reg.app) begin
                        s_next.page_out = RRC_PAGE_FACTORY;
                        s_next.app = 1'b0;
                    end else begin
                        s_next.page_out = s_reg.page_next;
                        s_next.app = (s_reg.page_next != RRC_PAGE_FACTORY);
                    end
                    s_next.fsm = RRC_ST_LOAD;
                end
            end
            default: begin
                s_next.fsm = RRC_ST_BOOT;
            end
        endcase
    end

    // Single state register, synchronous reset to power-on values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.fsm <= RRC_ST_BOOT;
            s_reg.cause <= RRC_STAT_RST;
            s_reg.wd_to <= RRC_WD_TO_RST;
            s_reg.page_out <= RRC_PAGE_FACTORY;
            s_reg.page_next <= RRC_PAGE_FACTORY;
            s_reg.bresp <= RRC_RESP_OKAY;
            s_reg.rresp <= RRC_RESP_OKAY;
        end else begin
            s_reg <= s_next;
        end
    end

    // Watchdog runs only in user mode of an application image
    assign wd_link.enable = s_reg.wd_en && s_reg.app &&
                            (s_reg.fsm == RRC_ST_USER);
    assign wd_link.kick = s_reg.kick;
    assign wd_link.timeout = s_reg.wd_to;

    rrc_watchdog #(
        .PRESCALE(WD_PRESCALE)
    ) u_watchdog (
        .aclk(aclk),
        .aresetn(aresetn),
        .wd(wd_link.dog)
    );

    // Outputs straight from the state register
    assign serial_out = s_reg.sr[0];
    assign page_select = s_reg.page_out;
    assign config_loading = (s_reg.fsm != RRC_ST_USER);
    assign user_mode = (s_reg.fsm == RRC_ST_USER);
    assign app_running = s_reg.app;
    assign s_axi_awready = s_reg.aw_rdy;
    assign s_axi_wready = s_reg.w_rdy;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = s_reg.ar_rdy;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
endmodule // rrc_top
`default_nettype wire

// ===== hdl/rrc_watchdog.sv
// User watchdog timer with tick prescaler
`timescale 1ns/1ps
`default_nettype none
module rrc_watchdog
    import rrc_pkg::*;
#(
    parameter int PRESCALE = RRC_WD_TICK_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    rrc_wd_if.dog wd
);
    localparam int PW = $clog2(PRESCALE + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);

    if (PRESCALE < 1) begin : g_bad_prescale
        $error("rrc_watchdog: PRESCALE must be at least 1");
    end

    typedef struct packed {
        logic [PW-1:0] pre;
        logic [RRC_WD_TO_W-1:0] cnt;
        logic expire;
    } rrc_wd_s;

    rrc_wd_s s_reg;
    rrc_wd_s s_next;

    // Tick enable from the prescaler advances the count
    always_comb begin
        s_next = s_reg;
        s_next.expire = 1'b0;
        if (!wd.enable || wd.kick) begin
            s_next.pre = '0;
            s_next.cnt = '0;
        end else if (s_reg.pre == PRE_LAST) begin
            s_next.pre = '0;
            if (s_reg.cnt >= wd.timeout) begin
                s_next.expire = 1'b1;
                s_next.cnt = '0;
            end else begin
                s_next.cnt = s_reg.cnt + 1'b1;
            end
        end else begin
            s_next.pre = s_reg.pre + 1'b1;
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wd.expire = s_reg.expire;
endmodule // rrc_watchdog
`default_nettype wire

// ===== inc/rrc_pkg.sv
// Constants, register map and types of the remote reconfiguration control
`default_nettype none
package rrc_pkg;
    // Clock and watchdog tick timing
    localparam int RRC_CLK_NS = 10;
    localparam int RRC_WD_TICK_NS = 10000;
    localparam int RRC_WD_TICK_CYC = RRC_WD_TICK_NS / RRC_CLK_NS;

    // Field widths
    localparam int RRC_STAT_W = 5;
    localparam int RRC_WD_TO_W = 12;
    localparam int RRC_PAGE_W = 3;
    localparam int RRC_DW = 32;
    localparam int RRC_AW = 5;

    // Register byte offsets
    localparam logic [RRC_AW-1:0] RRC_OFS_CTRL = 5'h00;
    localparam logic [RRC_AW-1:0] RRC_OFS_STATUS = 5'h04;
    localparam logic [RRC_AW-1:0] RRC_OFS_WDCFG = 5'h08;
    localparam logic [RRC_AW-1:0] RRC_OFS_PAGE = 5'h0c;

    // Control register bits (write-one pulses)
    localparam int RRC_CTRL_RECONF_BIT = 0;
    localparam int RRC_CTRL_KICK_BIT = 1;

    // Status register fields
    localparam int RRC_STAT_CAUSE_LSB = 0;
    localparam int RRC_STAT_APP_BIT = 8;
    localparam int RRC_STAT_PAGE_LSB = 12;
    localparam int RRC_STAT_LOAD_BIT = 16;
    localparam int RRC_STAT_USER_BIT = 17;

    // Watchdog configuration fields
    localparam int RRC_WD_TO_LSB = 0;
    localparam int RRC_WD_EN_BIT = 16;

    // Reconfiguration cause bit positions
    localparam int RRC_CAUSE_CRC = 0;
    localparam int RRC_CAUSE_EXT_ERR = 1;
    localparam int RRC_CAUSE_CORE = 2;
    localparam int RRC_CAUSE_EXT_REQ = 3;
    localparam int RRC_CAUSE_WDOG = 4;

    // Serial shift register layout
    localparam int RRC_SR_TO_LSB = 0;
    localparam int RRC_SR_EN_BIT = 12;
    localparam int RRC_SR_PAGE_LSB = 13;
    localparam int RRC_SR_APP_BIT = 16;
    localparam int RRC_SR_STAT_LSB = 17;
    localparam int RRC_SR_W = 22;

    // Pages and reset values
    localparam logic [RRC_PAGE_W-1:0] RRC_PAGE_FACTORY = 3'h0;
    localparam logic [RRC_PAGE_W-1:0] RRC_PAGE_LOCAL_APP = 3'h1;
    localparam logic [RRC_STAT_W-1:0] RRC_STAT_RST = 5'h00;
    localparam logic [RRC_WD_TO_W-1:0] RRC_WD_TO_RST = 12'h000;

    // Bus responses
    localparam logic [1:0] RRC_RESP_OKAY = 2'h0;
    localparam logic [1:0] RRC_RESP_SLVERR = 2'h2;

    // Configuration sequencer states
    typedef enum logic [2:0] {
        RRC_ST_BOOT = 3'b001,
        RRC_ST_LOAD = 3'b010,
        RRC_ST_USER = 3'b100
    } rrc_state_e;
endpackage
`default_nettype wire

// ===== inc/rrc_wd_if.sv
// Link between the sequencer and the user watchdog
`timescale 1ns/1ps
`default_nettype none
interface rrc_wd_if;
    import rrc_pkg::*;
    logic enable;
    logic kick;
    logic [RRC_WD_TO_W-1:0] timeout;
    logic expire;
    modport ctrl (output enable, output kick, output timeout, input expire);
    modport dog (input enable, input kick, input timeout, output expire);
endinterface
`default_nettype wire

// ===== tb/remote_reconfig_control_tb.sv
// Self-checking bench of the reconfiguration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
    fail_count++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module remote_reconfig_control_tb
    import rrc_pkg::*;
;
    typedef struct {
        logic [RRC_AW-1:0] a;
        logic [31:0] w;
        logic [31:0] r;
        logic [1:0] resp;
    } rrc_row_s;
    localparam logic [31:0] USR = 32'h1 << RRC_STAT_USER_BIT;
    localparam logic [31:0] APP = 32'h1 << RRC_STAT_APP_BIT;
    logic aclk, aresetn, shift_not_load, capture_not_update, serial_in;
    logic serial_out, watchdog_reset, reconfig_request, ext_config_request;
    logic remote_local_scheme_select, load_done, load_crc_error, load_ext_error;
    logic [RRC_PAGE_W-1:0] page_select;
    logic config_loading, user_mode, app_running, err_ext, slow;
    logic [7:0] bad_page;
    logic [RRC_AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [21:0] sr_got, nw;
    int fail_count, tests_run;
    rrc_row_s rows [6];

    // Short tick keeps watchdog expiry quick
    rrc_top #(.WD_PRESCALE(2)) rrc_top_i (.*);
    rrc_mem_model #(.LOAD_CYC(3)) rrc_mem_model_i (.*);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic tally_and_finish;
        $display("counts: %0d compared, %0d bad", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Write; an unknown response marks a hang
    task automatic axi_write(input logic [RRC_AW-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        resp = (n < 50) ? s_axi_bresp : 2'bxx;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [RRC_AW-1:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        rd = (n < 50) ? s_axi_rdata : 32'hx;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rd_chk(input logic [RRC_AW-1:0] a, input logic [31:0] e);
        axi_read(a);
        `CHK(rd, e)
        `CHK(resp, RRC_RESP_OKAY)
    endtask

    task automatic do_reset(input logic strap);
        @(posedge aclk);
        aresetn <= 1'b0;
        remote_local_scheme_select <= strap;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    task automatic req_pulse(input logic ext);
        @(posedge aclk);
        if (ext) ext_config_request <= 1'b1;
        else reconfig_request <= 1'b1;
        @(posedge aclk);
        ext_config_request <= 1'b0;
        reconfig_request <= 1'b0;
    endtask

    // Bounded wait; caller checks user_mode
    task automatic wait_user;
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (user_mode !== 1'b1 && n < 300);
    endtask

    // Hang guard, well above the expected run
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        $display("BAD %0t run did not finish", $time);
        tally_and_finish;
    end

    initial begin
        {aresetn, shift_not_load, serial_in, watchdog_reset} = 4'h0;
        {reconfig_request, ext_config_request, err_ext, slow} = 4'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
        s_axi_rready = 1'b0;
        {capture_not_update, remote_local_scheme_select} = 2'h3;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        bad_page = 8'h00;
        fail_count = 0;
        tests_run = 0;
        rows[0] = '{RRC_OFS_WDCFG, 32'h00010005, 32'h00010005, RRC_RESP_OKAY};
        rows[1] = '{RRC_OFS_PAGE, 32'h00000003, 32'h00000003, RRC_RESP_OKAY};
        rows[2] = '{5'h10, 32'h00001234, 32'h0, RRC_RESP_SLVERR};
        rows[3] = '{5'h1c, 32'hffffffff, 32'h0, RRC_RESP_SLVERR};
        rows[4] = '{RRC_OFS_STATUS, 32'hffffffff, USR, RRC_RESP_OKAY};
        rows[5] = '{RRC_OFS_CTRL, 32'h00000000, 32'h0, RRC_RESP_OKAY};
        do_reset(1'b1);
        repeat (3) @(posedge aclk);
        #1 `CHK({config_loading, page_select}, 4'h8)
        wait_user;
        `CHK({user_mode, app_running}, 2'b10)
        foreach (rows[i]) begin
            axi_write(rows[i].a, rows[i].w);
            `CHK(resp, rows[i].resp)
            axi_read(rows[i].a);
            `CHK({rd, resp}, {rows[i].r, rows[i].resp})
        end
        $display("register table done");
        // Read out the captured word while shifting a new one in
        nw = {5'h1f, 1'b1, 3'h2, 1'b1, 12'h007};
        @(posedge aclk);
        shift_not_load <= 1'b0;
        @(posedge aclk);
        shift_not_load <= 1'b1;
        serial_in <= nw[0];
        for (int i = 0; i < 22; i++) begin
            #1 sr_got[i] = serial_out;
            @(posedge aclk);
            serial_in <= nw[(i + 1) % 22];
        end
        `CHK(sr_got, {9'h003, 1'b1, 12'h005})
        shift_not_load <= 1'b0;
        capture_not_update <= 1'b0;
        @(posedge aclk);
        capture_not_update <= 1'b1;
        rd_chk(RRC_OFS_WDCFG, 32'h00010007);
        rd_chk(RRC_OFS_PAGE, 32'h2);
        $display("serial path done");
        watchdog_reset <= 1'b1;
        req_pulse(1'b0);
        repeat (2) @(posedge aclk);
        #1 `CHK({config_loading, page_select}, 4'ha)
        wait_user;
        `CHK({user_mode, app_running}, 2'b11)
        rd_chk(RRC_OFS_STATUS, USR | APP | 32'h2004);
        axi_write(RRC_OFS_WDCFG, 32'h00010fff);
        rd_chk(RRC_OFS_WDCFG, 32'h00010007);
        repeat (40) @(posedge aclk);
        `CHK(user_mode, 1'b1)
        watchdog_reset <= 1'b0;
        for (int n = 0; n < 60 && config_loading !== 1'b1; n++) @(posedge aclk);
        #1 `CHK({config_loading, page_select}, 4'h8)
        wait_user;
        rd_chk(RRC_OFS_STATUS, USR | 32'h10);
        $display("watchdog done");
        for (int k = 0; k < 2; k++) begin
            bad_page <= 8'h04;
            err_ext <= k[0];
            slow <= k[0];
            req_pulse(1'b0);
            repeat (4) @(posedge aclk);
            wait_user;
            `CHK(app_running, 1'b0)
            rd_chk(RRC_OFS_STATUS, USR | (32'h1 << k));
        end
        bad_page <= 8'h00;
        req_pulse(1'b1);
        repeat (2) @(posedge aclk);
        wait_user;
        rd_chk(RRC_OFS_STATUS, USR | 32'h8);
        watchdog_reset <= 1'b1;
        axi_write(RRC_OFS_CTRL, 32'h1);
        repeat (2) @(posedge aclk);
        wait_user;
        rd_chk(RRC_OFS_STATUS, USR | APP | 32'h2004);
        $display("reload causes done");
        do_reset(1'b0);
        repeat (4) @(posedge aclk);
        #1 `CHK({config_loading, app_running, page_select}, 5'h19)
        wait_user;
        rd_chk(RRC_OFS_PAGE, 32'h1);
        rd_chk(RRC_OFS_STATUS, USR | APP | 32'h1000);
        $display("local scheme done");
        tally_and_finish;
    end
endmodule // remote_reconfig_control_tb
`default_nettype wire

// ===== tb/rrc_mem_model.sv
// Paged configuration memory model
`timescale 1ns/1ps
`default_nettype none
module rrc_mem_model
    import rrc_pkg::*;
#(
    parameter int LOAD_CYC = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [RRC_PAGE_W-1:0] page_select,
    input wire logic config_loading,
    input wire logic [7:0] bad_page,
    input wire logic err_ext,
    input wire logic slow,
    output logic load_done,
    output logic load_crc_error,
    output logic load_ext_error
);
    logic [7:0] cnt;
    logic [RRC_PAGE_W-1:0] last_page;
    // A page change restarts the load, as a real memory would
    always_ff @(posedge aclk) begin
        load_done <= 1'b0;
        load_crc_error <= 1'b0;
        load_ext_error <= 1'b0;
        last_page <= page_select;
        if (!aresetn || !config_loading || page_select != last_page) begin
            cnt <= 8'h00;
        end else if (cnt == 8'(slow ? 3 * LOAD_CYC : LOAD_CYC)) begin
            cnt <= 8'h00;
            if (bad_page[page_select]) begin
                load_crc_error <= !err_ext;
                load_ext_error <= err_ext;
            end else begin
                load_done <= 1'b1;
            end
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule // rrc_mem_model
`default_nettype wire

// ===== tb/rrc_monitor.sv
// Port checker of the reconfiguration block
`timescale 1ns/1ps
`default_nettype none
module rrc_monitor
    import rrc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic shift_not_load,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic reconfig_request,
    input wire logic ext_config_request,
    input wire logic remote_local_scheme_select,
    input wire logic load_done,
    input wire logic load_crc_error,
    input wire logic load_ext_error,
    input wire logic [RRC_PAGE_W-1:0] page_select,
    input wire logic config_loading,
    input wire logic user_mode,
    input wire logic app_running,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    logic [4:0] shift_run;
    // Saturating run of shift cycles
    always_ff @(posedge aclk) begin
        if (!aresetn || !shift_not_load) begin
            shift_run <= 5'h00;
        end else if (shift_run != 5'h1f) begin
            shift_run <= shift_run + 5'h01;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_rd_taken; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_load_ok; config_loading && load_done; endsequence
    sequence s_load_bad;
        config_loading && !load_done && (load_crc_error || load_ext_error);
    endsequence
    a_shift_path: assert property (shift_run >= 5'd22 |->
        serial_out == $past(serial_in, 22)) else $error("serial bit lost");
    a_boot_page: assert property ($rose(aresetn) |-> ##[1:3]
        (config_loading && page_select == {2'b00, !remote_local_scheme_select}))
        else $error("wrong boot page");
    a_load_user: assert property (s_load_ok |=> user_mode)
        else $error("no user mode");
    a_err_factory: assert property (s_load_bad |=> config_loading &&
        !app_running && page_select == RRC_PAGE_FACTORY)
        else $error("no fallback");
    a_req_reload: assert property (user_mode && $rose(reconfig_request)
        |=> config_loading && (!$past(app_running) || page_select == 3'h0))
        else $error("request ignored");
    a_ext_reload: assert property (user_mode && $rose(ext_config_request)
        |=> config_loading && page_select == RRC_PAGE_FACTORY)
        else $error("ext request ignored");
    a_page_steady: assert property (user_mode && $past(user_mode)
        |-> $stable(page_select)) else $error("page moved in user mode");
    a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write answer late");
endmodule // rrc_monitor
bind rrc_top rrc_monitor rrc_monitor_i (.*);
`default_nettype wire
